// *** rtl/ecp_port_link.sv ***
// ECP parallel port: register decode, shared FIFO, pin handshakes.
// Assumes CPU strobes and port pins are asynchronous to clk_sys_i.
//
// Operation
// - Forward byte clocked by host strobe, busy-interlocked
// - Drive data only while reverse-ack line high (outside ECP mode the code drives by mode and direction bit instead)
// - Host ack high data, low command
// - Fault in forward raises error interrupt
// - Reverse request low selects reverse direction
// - Select-in held deasserted in ECP mode
// - Registers decoded at base-relative offsets
// - DMA address enable blocks register decode
// - Data latch cleared, written, driven out
// - Data port read returns pin levels
// - Offset zero write queues command byte
// - One shared sixteen-byte FIFO
// - Extended control top bits select mode
// - Config A reads constant 10h
`timescale 1ns/1ps
module ecp_port_link
    import ecp_port_pkg::*;
(
    // System
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    // CPU bus
    input wire logic [15:0] io_addr_i,
    input wire logic [15:0] port_base_i,
    input wire logic dma_address_enable_i,
    input wire logic io_write_strobe_n_i,
    input wire logic io_read_strobe_n_i,
    input wire logic [7:0] db_i,
    output logic [7:0] db_o,
    output logic db_oe_o,
    // Port outputs
    output logic host_strobe_out_n_o,
    output logic autofeed_out_n_o,
    output logic reverse_req_n_o,
    output logic select_in_out_n_o,
    output logic [7:0] port_data_lines_o,
    output logic port_data_lines_oe_o,
    output logic err_irq_o,
    // Port inputs
    input wire logic [7:0] port_data_lines_i,
    input wire logic busy_i,
    input wire logic periph_clk_n_i,
    input wire logic paper_error_in_i,
    input wire logic online_in_i,
    input wire logic fault_n_i
);
    import ecp_port_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE, ST_SETUP, ST_STROBE, ST_RELEASE,
        ST_REV_REQ, ST_REV_WAIT, ST_REV_ACK, ST_TURN
    } link_e;

    function automatic logic reg_hit(input logic [15:0] ofs,
                                     input logic dma_address_enable,
                                     input logic [15:0] want);
        reg_hit = !dma_address_enable && (ofs == want);
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers and CPU strobe edges
    logic [14:0] raw, s1_q, s2_q, s3_q, filt_q, filt_d;
    logic busy_f, ack_n_f, perr_f, online_in_f, fault_f, iow_f, ior_f;
    logic [7:0] pd_f;
    logic iow_p_q, ior_p_q, ior_pp_q, wr_evt, rd_evt;
    logic [15:0] addr_q, addr_d;
    logic [7:0] wdat_q, wdat_d;
    logic aen_q, aen_d;
    logic [15:0] ofs;

    assign raw = {busy_i, periph_clk_n_i, paper_error_in_i, online_in_i,
                  fault_n_i, io_write_strobe_n_i, io_read_strobe_n_i,
                  port_data_lines_i};
    assign {busy_f, ack_n_f, perr_f, online_in_f, fault_f, iow_f, ior_f,
            pd_f} = filt_q;
    assign wr_evt = !iow_p_q && iow_f;
    // Read decodes a cycle after capture, so it sees the new address
    assign rd_evt = ior_pp_q && !ior_p_q && !ior_f;
    assign ofs = addr_q - port_base_i;

    always_comb begin
        // A bit moves only when the two later stages agree
        filt_d = (s3_q & ~(s2_q ^ s3_q)) | (filt_q & (s2_q ^ s3_q));
        addr_d = addr_q;
        wdat_d = wdat_q;
        aen_d = aen_q;
        // Bus held stable through the strobe; sample once it is seen
        if ((iow_p_q && !iow_f) || (ior_p_q && !ior_f)) begin
            addr_d = io_addr_i;
            wdat_d = db_i;
            aen_d = dma_address_enable_i;
        end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s1_q <= SYNC_RST;
            s2_q <= SYNC_RST;
            s3_q <= SYNC_RST;
            filt_q <= SYNC_RST;
            iow_p_q <= 1'b1;
            ior_p_q <= 1'b1;
            ior_pp_q <= 1'b1;
            addr_q <= '0;
            wdat_q <= '0;
            aen_q <= 1'b1;
        end else begin
            s1_q <= raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
            filt_q <= filt_d;
            iow_p_q <= iow_f;
            ior_p_q <= ior_f;
            ior_pp_q <= ior_p_q;
            addr_q <= addr_d;
            wdat_q <= wdat_d;
            aen_q <= aen_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Register file
    logic [7:0] data_q, data_d;
    logic [5:0] dcr_q, dcr_d;
    mode_e mode_q, mode_d;
    logic [2:0] ecr_hi_q, ecr_hi_d;
    logic [5:0] cfgb_q, cfgb_d;
    logic h0, h1, h2, h400, h401, h402;
    logic ecp, cfifo, legacy, dir;

    assign h0 = reg_hit(ofs, aen_q, OFS_DATA);
    assign h1 = reg_hit(ofs, aen_q, OFS_DSR);
    assign h2 = reg_hit(ofs, aen_q, OFS_DCR);
    assign h400 = reg_hit(ofs, aen_q, OFS_FIFO);
    assign h401 = reg_hit(ofs, aen_q, OFS_CFGB);
    assign h402 = reg_hit(ofs, aen_q, OFS_ECR);
    assign ecp = (mode_q == MODE_ECP);
    assign cfifo = (mode_q == MODE_CFIFO);
    assign legacy = (mode_q == MODE_SPP) || (mode_q == MODE_PS2);
    assign dir = dcr_q[DCR_DIR];

    always_comb begin
        data_d = data_q;
        dcr_d = dcr_q;
        mode_d = mode_q;
        ecr_hi_d = ecr_hi_q;
        cfgb_d = cfgb_q;
        if (wr_evt) begin
            if (h0 && legacy) begin
                data_d = wdat_q;
            end
            if (h2) begin
                dcr_d = wdat_q[5:0];
            end
            if (h401 && mode_q == MODE_CFG) begin
                cfgb_d = wdat_q[5:0];
            end
            if (h402) begin
                mode_d = mode_e'(wdat_q[7:5]);
                ecr_hi_d = wdat_q[4:2];
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            data_q <= DATA_RST;
            dcr_q <= DCR_RST;
            mode_q <= MODE_SPP;
            ecr_hi_q <= ECR_HI_RST;
            cfgb_q <= CFGB_RST;
        end else begin
            data_q <= data_d;
            dcr_q <= dcr_d;
            mode_q <= mode_d;
            ecr_hi_q <= ecr_hi_d;
            cfgb_q <= cfgb_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Shared FIFO; bit 8 marks an address/RLE command byte
    logic [8:0] fifo_q [FIFO_DEPTH];
    logic [3:0] wp_q, wp_d, rp_q, rp_d;
    logic [4:0] cnt_q, cnt_d;
    logic [7:0] last_q, last_d;
    logic full, empty, flush, push, pop, cpu_push, cpu_pop, rev_push;
    logic drain, buf_in_rdy, buf_vld, buf_rdy;
    logic [8:0] push_w, buf_w;

    assign full = (cnt_q == FIFO_FULL);
    assign empty = (cnt_q == 5'd0);
    // Legacy modes hold the FIFO in reset
    assign flush = legacy;
    assign drain = cfifo || (ecp && !dir);
    assign cpu_push = wr_evt && !full && ((h0 && ecp) ||
        (h400 && (cfifo || ecp || mode_q == MODE_TEST)));
    // Test FIFO reads never stall: empty re-reads the last byte
    assign cpu_pop = rd_evt && h400 && !empty && !drain &&
        (ecp || mode_q == MODE_TEST);
    assign push = cpu_push || rev_push;
    assign pop = cpu_pop || (drain && !empty && buf_in_rdy);
    assign push_w = rev_push ? {!busy_f, pd_f} :
        {h0 && ecp, wdat_q};

    always_comb begin
        wp_d = wp_q;
        rp_d = rp_q;
        last_d = last_q;
        if (push) begin
            wp_d = wp_q + 4'd1;
        end
        if (pop) begin
            rp_d = rp_q + 4'd1;
            last_d = fifo_q[rp_q][7:0];
        end
        cnt_d = cnt_q + {4'd0, push} - {4'd0, pop};
        if (flush) begin
            wp_d = 4'd0;
            rp_d = 4'd0;
            cnt_d = 5'd0;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (push) begin
            fifo_q[wp_q] <= push_w;
        end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wp_q <= 4'd0;
            rp_q <= 4'd0;
            cnt_q <= 5'd0;
            last_q <= 8'h00;
        end else begin
            wp_q <= wp_d;
            rp_q <= rp_d;
            cnt_q <= cnt_d;
            last_q <= last_d;
        end
    end

    ecp_skid_buffer #(.W(WORD_W)) u_skid (
        .clk_sys_i(clk_sys_i),
        .nrst_i(nrst_i),
        .flush_i(flush),
        .in_valid_i(drain && !empty),
        .in_ready_o(buf_in_rdy),
        .in_data_i(fifo_q[rp_q]),
        .out_valid_o(buf_vld),
        .out_ready_i(buf_rdy),
        .out_data_o(buf_w)
    );

    ////////////////////////////////////////////////////////////////////
    // Link handshake engine
    link_e st_q, st_d;
    logic [8:0] cur_q, cur_d;
    logic fwd_st, rev_st, hostack;

    assign fwd_st = (st_q == ST_IDLE) || (st_q == ST_SETUP) ||
        (st_q == ST_STROBE) || (st_q == ST_RELEASE);
    assign rev_st = (st_q == ST_REV_REQ) || (st_q == ST_REV_WAIT) ||
        (st_q == ST_REV_ACK);

    always_comb begin
        st_d = st_q;
        cur_d = cur_q;
        buf_rdy = 1'b0;
        rev_push = 1'b0;
        unique case (st_q)
            ST_IDLE: begin
                if (ecp && dir) begin
                    st_d = ST_REV_REQ;
                end else if ((ecp || cfifo) && buf_vld && !busy_f) begin
                    buf_rdy = 1'b1;
                    cur_d = buf_w;
                    st_d = ST_SETUP;
                end
            end
            // One cycle of data setup ahead of the strobe
            ST_SETUP: st_d = ST_STROBE;
            ST_STROBE: if (busy_f) st_d = ST_RELEASE;
            ST_RELEASE: if (!busy_f) st_d = ST_IDLE;
            ST_REV_REQ: begin
                if (!(ecp && dir)) begin
                    st_d = ST_TURN;
                end else if (!perr_f) begin
                    st_d = ST_REV_WAIT;
                end
            end
            ST_REV_WAIT: begin
                if (!(ecp && dir)) begin
                    st_d = ST_TURN;
                // CPU push wins; the peripheral byte waits a cycle
                end else if (!ack_n_f && !full && !cpu_push) begin
                    rev_push = 1'b1;
                    st_d = ST_REV_ACK;
                end
            end
            ST_REV_ACK: if (ack_n_f) st_d = ST_REV_WAIT;
            ST_TURN: if (perr_f) st_d = ST_IDLE;
        endcase
        if (!(ecp || cfifo) && fwd_st) begin
            st_d = ST_IDLE;
        end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_q <= ST_IDLE;
            cur_q <= WORD_RST;
        end else begin
            st_q <= st_d;
            cur_q <= cur_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Pin drive
    always_comb begin
        hostack = 1'b1;
        if (st_q == ST_SETUP || st_q == ST_STROBE || st_q == ST_RELEASE) begin
            hostack = !cur_q[8];
        end else if (st_q == ST_REV_WAIT || st_q == ST_REV_REQ) begin
            hostack = 1'b0;
        end
    end

    assign host_strobe_out_n_o = (ecp || cfifo) ? (st_q != ST_STROBE) :
        !dcr_q[DCR_STB];
    assign autofeed_out_n_o = ecp ? hostack : !dcr_q[DCR_AFD];
    assign reverse_req_n_o = ecp ? !rev_st : dcr_q[DCR_INIT];
    assign select_in_out_n_o = ecp ? 1'b1 : !dcr_q[DCR_SELECT_IN_OUT];
    assign port_data_lines_o = (ecp || cfifo) ? cur_q[7:0] : data_q;
    // In ECP mode ownership follows the reverse-ack line; other modes decide it by mode and direction bit
    assign port_data_lines_oe_o = ecp ? (fwd_st && perr_f) :
        ((mode_q == MODE_SPP) || cfifo || !dir);
    assign err_irq_o = ecp && fwd_st && !fault_f &&
        !ecr_hi_q[ECR_ERRN];

    ////////////////////////////////////////////////////////////////////
    // CPU read path
    logic [7:0] rd_q, rd_d;
    logic rdv_q, rdv_d;

    always_comb begin
        rd_d = rd_q;
        rdv_d = rdv_q && !ior_f;
        if (rd_evt) begin
            rdv_d = h0 || h1 || h2 || h400 || h401 || h402;
            rd_d = 8'h00;
            if (h0 && legacy) begin
                rd_d = pd_f;
            end else if (h1) begin
                rd_d = {!busy_f, ack_n_f, perr_f, online_in_f, fault_f, 3'b111};
            end else if (h2) begin
                rd_d = {2'b11, dcr_q};
            end else if (h400 && mode_q == MODE_CFG) begin
                rd_d = CFGA_VALUE;
            end else if (h400 && (ecp || mode_q == MODE_TEST)) begin
                rd_d = empty ? last_q : fifo_q[rp_q][7:0];
            end else if (h401 && mode_q == MODE_CFG) begin
                rd_d = {1'b0, err_irq_o, cfgb_q};
            end else if (h402) begin
                rd_d = {mode_q, ecr_hi_q, full, empty};
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rd_q <= 8'h00;
            rdv_q <= 1'b0;
        end else begin
            rd_q <= rd_d;
            rdv_q <= rdv_d;
        end
    end

    assign db_o = rd_q;
    assign db_oe_o = rdv_q && !ior_f;

    ////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);

    chk_strobe_release: assert property (
        st_q == ST_STROBE && busy_f |=> host_strobe_out_n_o)
        else $error("strobe not released after busy");
    chk_strobe_idle: assert property (
        $rose(st_q == ST_SETUP) |-> $past(!busy_f))
        else $error("byte started while peripheral busy");
    chk_hostack_tag: assert property (
        ecp && st_q == ST_STROBE |-> autofeed_out_n_o == !cur_q[8])
        else $error("host ack does not match byte tag");
    chk_rev_request: assert property (
        ecp && dir && st_q == ST_IDLE |=> !reverse_req_n_o)
        else $error("reverse request not driven low");
    chk_select_in_out_ecp: assert property (
        ecp |-> select_in_out_n_o)
        else $error("select-in asserted in ECP mode");
    chk_pd_released: assert property (
        ecp && (rev_st || !perr_f) |-> !port_data_lines_oe_o)
        else $error("data lines driven while reversed");
    chk_err_irq: assert property (
        ecp && !dir && st_q == ST_IDLE && !fault_f && !ecr_hi_q[ECR_ERRN]
        |-> err_irq_o)
        else $error("fault did not raise error interrupt");
    chk_data_write: assert property (
        wr_evt && h0 && legacy |=> data_q == $past(wdat_q))
        else $error("data latch missed a write");
    chk_aen_block: assert property (
        wr_evt && aen_q |=> $stable(data_q) && $stable(mode_q))
        else $error("write decoded during DMA cycle");
    chk_fifo_bound: assert property (
        cnt_q <= FIFO_FULL)
        else $error("FIFO count above depth");
    chk_cfga_read: assert property (
        rd_evt && h400 && mode_q == MODE_CFG |=> rd_q == CFGA_VALUE)
        else $error("config A read wrong value");
endmodule // ecp_port_link

// *** rtl/ecp_port_pkg.sv ***
// Package: offsets, reset values and modes of the ECP port block.
// Assumes a CPU bus whose strobes are asynchronous to clk_sys_i.
package ecp_port_pkg;
    // Register offsets from the port base address
    localparam logic [15:0] OFS_DATA = 16'h0000;
    localparam logic [15:0] OFS_DSR = 16'h0001;
    localparam logic [15:0] OFS_DCR = 16'h0002;
    localparam logic [15:0] OFS_FIFO = 16'h0400;
    localparam logic [15:0] OFS_CFGB = 16'h0401;
    localparam logic [15:0] OFS_ECR = 16'h0402;
    // Field positions
    localparam int DCR_STB = 0;
    localparam int DCR_AFD = 1;
    localparam int DCR_INIT = 2;
    localparam int DCR_SELECT_IN_OUT = 3;
    localparam int DCR_DIR = 5;
    localparam int ECR_ERRN = 2;
    // Reset and fixed values
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [5:0] DCR_RST = 6'h00;
    localparam logic [2:0] ECR_HI_RST = 3'h5;
    localparam logic [5:0] CFGB_RST = 6'h00;
    localparam logic [7:0] CFGA_VALUE = 8'h10;
    localparam logic [14:0] SYNC_RST = 15'h7f00;
    localparam logic [8:0] WORD_RST = 9'h000;
    // Shared FIFO geometry
    localparam int FIFO_DEPTH = 16;
    localparam logic [4:0] FIFO_FULL = 5'h10;
    localparam int WORD_W = 9;
    typedef enum logic [2:0] {
        MODE_SPP = 3'b000,
        MODE_PS2 = 3'b001,
        MODE_CFIFO = 3'b010,
        MODE_ECP = 3'b011,
        MODE_EPP = 3'b100,
        MODE_RSV = 3'b101,
        MODE_TEST = 3'b110,
        MODE_CFG = 3'b111
    } mode_e;
endpackage

// *** rtl/ecp_skid_buffer.sv ***
// Two-entry buffer between the shared FIFO and the strobe engine.
// Assumes one clock; flush_i empties it in one cycle.
`timescale 1ns/1ps
module ecp_skid_buffer #(
    parameter int W = 9
) (
    // System
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic flush_i,
    // Fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [W-1:0] in_data_i,
    // Drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [W-1:0] out_data_o
);
    logic [W-1:0] mem_q [2];
    logic [W-1:0] mem_d [2];
    logic wp_q, wp_d, rp_q, rp_d;
    logic [1:0] cnt_q, cnt_d;
    logic wr, rd;

    assign in_ready_o = (cnt_q != 2'd2);
    assign out_valid_o = (cnt_q != 2'd0);
    assign out_data_o = mem_q[rp_q];

    always_comb begin
        wr = in_valid_i && in_ready_o;
        rd = out_valid_o && out_ready_i;
        mem_d = mem_q;
        wp_d = wp_q;
        rp_d = rp_q;
        cnt_d = cnt_q;
        if (wr) begin
            mem_d[wp_q] = in_data_i;
            wp_d = ~wp_q;
        end
        if (rd) begin
            rp_d = ~rp_q;
        end
        cnt_d = cnt_q + {1'b0, wr} - {1'b0, rd};
        if (flush_i) begin
            wp_d = 1'b0;
            rp_d = 1'b0;
            cnt_d = 2'd0;
        end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            mem_q[0] <= '0;
            mem_q[1] <= '0;
            wp_q <= 1'b0;
            rp_q <= 1'b0;
            cnt_q <= 2'd0;
        end else begin
            mem_q <= mem_d;
            wp_q <= wp_d;
            rp_q <= rp_d;
            cnt_q <= cnt_d;
        end
    end
endmodule // ecp_skid_buffer

// *** dv/ecp_periph_model.sv ***
// Behavioural ECP peripheral facing the port link pins.
// Assumes the bench clock; host pins are seen as plain levels.
`timescale 1ns/1ps
module ecp_periph_model (
    // Clock and bench control
    input wire logic clk_sys_i,
    input wire logic stall_i,
    // Host pins
    input wire logic strobe_n_i,
    input wire logic hostack_i,
    input wire logic rev_req_n_i,
    input wire logic [7:0] pd_i,
    // Peripheral pins
    output logic [7:0] pd_o,
    output logic busy_o,
    output logic pclk_n_o,
    output logic ackrev_n_o
);
    logic [8:0] got[$];
    logic [8:0] tx[$];
    logic [8:0] w;
    initial begin
        {pd_o, busy_o, pclk_n_o, ackrev_n_o} = 11'h003;
        forever begin
            @(posedge clk_sys_i);
            if (rev_req_n_i != ackrev_n_o) begin
                // Slow turnaround so the host must really wait
                repeat (4) @(posedge clk_sys_i);
                ackrev_n_o <= rev_req_n_i;
                busy_o <= 1'b0;
            end else if (!ackrev_n_o && tx.size() > 0 && !hostack_i) begin
                w = tx.pop_front();
                pd_o <= w[7:0];
                busy_o <= ~w[8];
                @(posedge clk_sys_i);
                pclk_n_o <= 1'b0;
                while (!hostack_i) @(posedge clk_sys_i);
                pclk_n_o <= 1'b1;
                // Released lines show the inverse, not the old byte
                pd_o <= ~w[7:0];
                while (hostack_i) @(posedge clk_sys_i);
            end else if (ackrev_n_o && !strobe_n_i && !busy_o) begin
                got.push_back({~hostack_i, pd_i});
                busy_o <= 1'b1;
                while (!strobe_n_i || stall_i) @(posedge clk_sys_i);
                busy_o <= 1'b0;
            end
        end
    end
endmodule // ecp_periph_model

// *** dv/test_ecp_port_link.sv ***
// Self-checking bench for the ECP port link.
// Assumes the package and the peripheral model are compiled first.
`timescale 1ns/1ps
module test_ecp_port_link;
    import ecp_port_pkg::*;
    logic clk_sys_i, nrst_i, dma_address_enable, wr_n, rd_n, stall, fault_n, online;
    logic db_oe, stb_n, afd_n, rreq_n, select_in_out_n, pdoe, irq, busy, pclk_n;
    logic ackr_n, oe, full;
    logic [15:0] addr, base;
    logic [7:0] db, db_o, pdo, pdi, ppd, q;
    logic [31:0] seed, r;
    logic [8:0] exp_q[$];
    int fail_count, tests_run;
    assign pdi = pdoe ? pdo : ppd;

    ecp_port_link u_dut (
        .clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
        .io_addr_i(addr), .port_base_i(base),
        .dma_address_enable_i(dma_address_enable), .io_write_strobe_n_i(wr_n),
        .io_read_strobe_n_i(rd_n), .db_i(db), .db_o(db_o),
        .db_oe_o(db_oe), .host_strobe_out_n_o(stb_n),
        .autofeed_out_n_o(afd_n), .reverse_req_n_o(rreq_n),
        .select_in_out_n_o(select_in_out_n), .port_data_lines_o(pdo),
        .port_data_lines_oe_o(pdoe), .err_irq_o(irq),
        .port_data_lines_i(pdi), .busy_i(busy), .periph_clk_n_i(pclk_n),
        .paper_error_in_i(ackr_n), .online_in_i(online),
        .fault_n_i(fault_n));
    ecp_periph_model u_per (
        .clk_sys_i(clk_sys_i), .stall_i(stall), .strobe_n_i(stb_n),
        .hostack_i(afd_n), .rev_req_n_i(rreq_n), .pd_i(pdi),
        .pd_o(ppd), .busy_o(busy), .pclk_n_o(pclk_n),
        .ackrev_n_o(ackr_n));

    ////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [7:0] dcr_rd(input logic [5:0] d);
        return {2'b11, d};
    endfunction
    task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Strobes far longer than the filter, ends settled at a falling edge
    task automatic bus(input logic w, input logic [15:0] ofs,
                       input logic [7:0] d, input logic a);
        @(posedge clk_sys_i);
        addr <= base + ofs;
        db <= d;
        dma_address_enable <= a;
        if (w) wr_n <= 1'b0;
        else rd_n <= 1'b0;
        repeat (7) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        q = db_o;
        oe = db_oe;
        @(posedge clk_sys_i);
        wr_n <= 1'b1;
        rd_n <= 1'b1;
        repeat (7) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
    endtask
    task automatic complete_run();
        $display("checks=%0d mismatches=%0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys_i = 1'b0;
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end
    initial begin
        repeat (40000) @(posedge clk_sys_i);
        fail_count++;
        complete_run();
    end
    initial begin
        seed = 32'd68095;
        {nrst_i, wr_n, rd_n, dma_address_enable, stall, fault_n, online} = 7'b0110011;
        addr = 16'h0000;
        db = 8'h00;
        base = 16'h0378;
        fail_count = 0;
        tests_run = 0;
        repeat (16) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        repeat (2) @(negedge clk_sys_i);
        chk(pdo, 8'h00);
        chk({stb_n, select_in_out_n}, 2'b11);
        bus(0, OFS_DCR, 8'h00, 0);
        chk(q, dcr_rd(6'h00));
        bus(0, OFS_DSR, 8'h00, 0);
        chk(q, 8'hDF);
        bus(0, OFS_ECR, 8'h00, 0);
        chk(q, 8'h15);
        for (int i = 0; i < 4; i++) begin
            r = rnd();
            bus(1, OFS_DATA, r[7:0], 0);
            chk(pdo, r[7:0]);
            bus(0, OFS_DATA, 8'h00, 0);
            chk(q, r[7:0]);
            bus(1, OFS_DATA, ~r[7:0], 1);
            chk(pdo, r[7:0]);
        end
        bus(0, 16'h0003, 8'h00, 0);
        chk(oe, 1'b0);
        bus(0, OFS_DCR, 8'h00, 1);
        chk(oe, 1'b0);
        for (int m = 0; m < 8; m++) begin
            bus(1, OFS_ECR, {m[2:0], 5'h00}, 0);
            bus(0, OFS_ECR, 8'h00, 0);
            chk(q[7:5], m[2:0]);
        end
        bus(0, OFS_FIFO, 8'h00, 0);
        chk(q, 8'h10);
        // Forward: stalled peripheral lets the FIFO fill and refuse
        bus(1, OFS_ECR, 8'h60, 0);
        bus(1, OFS_DCR, 8'h0C, 0);
        chk({select_in_out_n, rreq_n}, 2'b11);
        stall <= 1'b1;
        for (int i = 0; i < 24; i++) begin
            bus(0, OFS_ECR, 8'h00, 0);
            full = q[1];
            r = rnd();
            bus(1, r[8] ? OFS_DATA : OFS_FIFO, r[7:0], 0);
            if (full) break;
            exp_q.push_back(r[8:0]);
        end
        chk(full, 1'b1);
        chk(exp_q.size() >= 16, 1'b1);
        stall <= 1'b0;
        for (int i = 0; i < 3000 && u_per.got.size() < exp_q.size(); i++)
            @(posedge clk_sys_i);
        repeat (40) @(negedge clk_sys_i);
        chk(u_per.got.size(), exp_q.size());
        foreach (exp_q[i]) chk(u_per.got[i], exp_q[i]);
        @(posedge clk_sys_i) fault_n <= 1'b0;
        repeat (8) @(negedge clk_sys_i);
        chk(irq, 1'b1);
        @(posedge clk_sys_i) fault_n <= 1'b1;
        // Reverse: fault must not raise the error while reversed
        r = rnd();
        u_per.tx.push_back({1'b0, r[7:0]});
        u_per.tx.push_back({1'b1, r[15:8]});
        bus(1, OFS_DCR, 8'h2C, 0);
        @(posedge clk_sys_i) fault_n <= 1'b0;
        repeat (100) @(negedge clk_sys_i);
        chk(irq, 1'b0);
        chk({rreq_n, pdoe}, 2'b00);
        bus(0, OFS_FIFO, 8'h00, 0);
        chk(q, r[7:0]);
        bus(0, OFS_FIFO, 8'h00, 0);
        chk(q, r[15:8]);
        @(posedge clk_sys_i) fault_n <= 1'b1;
        bus(1, OFS_DCR, 8'h0C, 0);
        repeat (30) @(negedge clk_sys_i);
        chk({rreq_n, pdoe}, 2'b11);
        // Compatibility FIFO shares the same storage and strobe engine
        bus(1, OFS_ECR, 8'h40, 0);
        r = rnd();
        bus(1, OFS_FIFO, r[7:0], 0);
        repeat (40) @(negedge clk_sys_i);
        chk(u_per.got.size(), exp_q.size() + 1);
        chk(u_per.got[exp_q.size()], {1'b0, r[7:0]});
        complete_run();
    end
endmodule // test_ecp_port_link
